// file: rtl/dsfr_regs.svh
/*
  timing and framing constants for the serial frame receiver.
  assumes inclusion by bare name from the receiver files.
*/
`ifndef DSFR_REGS_SVH
`define DSFR_REGS_SVH
`define DSFR_FRAME_BITS 24
`define DSFR_CNT_W 5
`define DSFR_WORD_RST 24'h000000
`define DSFR_CNT_RST 5'h00
`define DSFR_LAST_BIT 5'h17
`define DSFR_FULL_CNT 5'h18
`endif

// file: rtl/dsfr_pkg.sv
/*
  types of the serial frame receiver.
  assumes dsfr_regs.svh is on the include path.
*/
`include "dsfr_regs.svh"
package dsfr_pkg;
  typedef logic [`DSFR_FRAME_BITS-1:0] dsfr_word_t;
  typedef logic [`DSFR_CNT_W-1:0] dsfr_cnt_t;
  typedef enum logic [1:0] {
    DSFR_IDLE = 2'b00,
    DSFR_SHIFT = 2'b01,
    DSFR_DONE = 2'b10
  } dsfr_state_t;
endpackage : dsfr_pkg

// file: rtl/dsfr_sync.sv
/*
  two flip-flop synchroniser bank for the pin inputs.
  assumes pins are asynchronous to clk.
*/
`timescale 1ns/10ps
module dsfr_sync (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [2:0] pin_in,
  output logic [2:0] pin_sync
);
  logic [2:0] meta_reg;
  // first stage feeds only the second; idle levels high on frame and clock
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_reg <= 3'h6;
      pin_sync <= 3'h6;
    end else begin
      meta_reg <= pin_in;
      pin_sync <= meta_reg;
    end
  end
endmodule : dsfr_sync

// file: rtl/dsfr_rx.sv
/*
  serial frame receiver: frame-sync, serial clock and data pins in, 24-bit word out.
  assumes clk at 200 MHz oversamples the serial clock (link period 64 ns in bench).
*/
`timescale 1ns/10ps
`include "dsfr_regs.svh"
module dsfr_rx (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic frame_n_pin,
  input wire logic sclk_pin,
  input wire logic sdin_pin,
  output dsfr_pkg::dsfr_word_t word_reg,
  output logic word_valid_reg,
  output logic abort_reg,
  output logic busy_reg
);
  logic [2:0] pins_s;
  logic frame_n_s, sclk_s, sdin_s;
  logic frame_n_d_reg, sclk_d_reg;
  logic frame_fall, frame_rise, sclk_fall;
  dsfr_pkg::dsfr_state_t state_reg;
  dsfr_pkg::dsfr_word_t shift_reg;
  dsfr_pkg::dsfr_cnt_t cnt_reg;

  dsfr_sync u_sync (
    .clk(clk),
    .rst_n(rst_n),
    .pin_in({frame_n_pin, sclk_pin, sdin_pin}),
    .pin_sync(pins_s)
  );
  assign frame_n_s = pins_s[2];
  assign sclk_s = pins_s[1];
  assign sdin_s = pins_s[0];

  // edge history taken from synchronised levels only
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      frame_n_d_reg <= 1'b1;
      sclk_d_reg <= 1'b1;
    end else begin
      frame_n_d_reg <= frame_n_s;
      sclk_d_reg <= sclk_s;
    end
  end
  assign frame_fall = frame_n_d_reg & ~frame_n_s;
  assign frame_rise = ~frame_n_d_reg & frame_n_s;
  assign sclk_fall = sclk_d_reg & ~sclk_s;

  // frame sequencing; clock and data are ignored while idle or done
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= dsfr_pkg::DSFR_IDLE;
    end else begin
      case (state_reg)
        dsfr_pkg::DSFR_IDLE: begin
          if (frame_fall) state_reg <= dsfr_pkg::DSFR_SHIFT;
        end
        dsfr_pkg::DSFR_SHIFT: begin
          if (frame_n_s) state_reg <= dsfr_pkg::DSFR_IDLE;
          else if (sclk_fall && cnt_reg == `DSFR_LAST_BIT)
            state_reg <= dsfr_pkg::DSFR_DONE;
        end
        dsfr_pkg::DSFR_DONE: begin
          // extra clocks after the word are ignored until frame-sync rises
          if (frame_n_s) state_reg <= dsfr_pkg::DSFR_IDLE;
        end
        default: state_reg <= dsfr_pkg::DSFR_IDLE;
      endcase
    end
  end

  // bit counter cleared at every frame start
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_reg <= `DSFR_CNT_RST;
    end else if (frame_fall) begin
      cnt_reg <= `DSFR_CNT_RST;
    end else if (state_reg == dsfr_pkg::DSFR_SHIFT && !frame_n_s && sclk_fall) begin
      cnt_reg <= cnt_reg + 5'h01;
    end
  end

  // shift msb first on each falling serial clock edge in the shift state
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      shift_reg <= `DSFR_WORD_RST;
    end else if (state_reg == dsfr_pkg::DSFR_SHIFT && !frame_n_s && sclk_fall) begin
      shift_reg <= {shift_reg[`DSFR_FRAME_BITS-2:0], sdin_s};
    end
  end

  // word output updates only on a complete frame, so an abort never leaks
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      word_reg <= `DSFR_WORD_RST;
      word_valid_reg <= 1'b0;
    end else begin
      word_valid_reg <= 1'b0;
      if (state_reg == dsfr_pkg::DSFR_SHIFT && !frame_n_s && sclk_fall &&
          cnt_reg == `DSFR_LAST_BIT) begin
        word_reg <= {shift_reg[`DSFR_FRAME_BITS-2:0], sdin_s};
        word_valid_reg <= 1'b1;
      end
    end
  end

  // status pulses and levels for the decoder side
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      abort_reg <= 1'b0;
      busy_reg <= 1'b0;
    end else begin
      abort_reg <= (state_reg == dsfr_pkg::DSFR_SHIFT) && frame_n_s;
      busy_reg <= !frame_n_s;
    end
  end

  // counter stops at the full frame length; extra falls in done never count
  cnt_bound_a: assert property (@(posedge clk) disable iff (!rst_n)
    cnt_reg <= `DSFR_FULL_CNT)
    else $error("bit counter ran past frame length");

  // done is only reached with exactly 24 bits taken
  done_count_a: assert property (@(posedge clk) disable iff (!rst_n)
    state_reg == dsfr_pkg::DSFR_DONE |-> cnt_reg == `DSFR_FULL_CNT)
    else $error("done state with short count");

  // counter holds while idle unless a new frame starts
  idle_count_a: assert property (@(posedge clk) disable iff (!rst_n)
    (state_reg == dsfr_pkg::DSFR_IDLE && !frame_fall) |=> $stable(cnt_reg))
    else $error("counter moved while idle");

  // word output only moves together with its valid pulse
  word_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
    !word_valid_reg |-> $stable(word_reg))
    else $error("word changed without valid");

  // presented word is the shifter plus the final bit
  valid_word_a: assert property (@(posedge clk) disable iff (!rst_n)
    word_valid_reg |-> word_reg == $past({shift_reg[`DSFR_FRAME_BITS-2:0], sdin_s}))
    else $error("presented word not the shifted bits");

  // trailing clocks after a full word never raise a second valid
  done_quiet_a: assert property (@(posedge clk) disable iff (!rst_n)
    state_reg == dsfr_pkg::DSFR_DONE |=> !word_valid_reg)
    else $error("second valid in one frame");

  // abort only follows a frame rise in the shift state
  abort_cause_a: assert property (@(posedge clk) disable iff (!rst_n)
    abort_reg |-> $past(state_reg) == dsfr_pkg::DSFR_SHIFT && $past(frame_n_s))
    else $error("abort without early frame end");

  // an early frame end always reports an abort
  abort_flag_a: assert property (@(posedge clk) disable iff (!rst_n)
    (state_reg == dsfr_pkg::DSFR_SHIFT && frame_n_s) |=> abort_reg)
    else $error("early frame end not flagged");

  // abort is a single-cycle pulse
  abort_once_a: assert property (@(posedge clk) disable iff (!rst_n)
    abort_reg |=> !abort_reg)
    else $error("abort longer than one cycle");

  // no bit may enter while the frame is high
  high_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
    frame_n_s |=> $stable(shift_reg))
    else $error("bit taken outside frame");

  // busy mirrors the synchronised frame one cycle late
  busy_track_a: assert property (@(posedge clk) disable iff (!rst_n)
    busy_reg == !$past(frame_n_s))
    else $error("busy does not follow frame");

  valid_once_a: assert property (@(posedge clk) disable iff (!rst_n)
    word_valid_reg |=> !word_valid_reg)
    else $error("word valid longer than one cycle");
  valid_cause_a: assert property (@(posedge clk) disable iff (!rst_n)
    word_valid_reg |-> $past(state_reg) == dsfr_pkg::DSFR_SHIFT && state_reg == dsfr_pkg::DSFR_DONE)
    else $error("word valid without final edge");
  abort_drop_a: assert property (@(posedge clk) disable iff (!rst_n)
    abort_reg |-> $stable(word_reg) && !word_valid_reg)
    else $error("aborted frame touched the word");
  start_arm_a: assert property (@(posedge clk) disable iff (!rst_n)
    (state_reg == dsfr_pkg::DSFR_IDLE && frame_fall) |=>
      state_reg == dsfr_pkg::DSFR_SHIFT && cnt_reg == `DSFR_CNT_RST)
    else $error("frame start did not arm shifter");
  shift_step_a: assert property (@(posedge clk) disable iff (!rst_n)
    (state_reg == dsfr_pkg::DSFR_SHIFT && !frame_n_s && sclk_fall) |=>
      shift_reg[0] == $past(sdin_s) && cnt_reg == $past(cnt_reg) + 5'h01)
    else $error("shift step wrong");
  idle_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
    (state_reg != dsfr_pkg::DSFR_SHIFT) |=> $stable(shift_reg))
    else $error("shift outside a frame");
  abort_idle_a: assert property (@(posedge clk) disable iff (!rst_n)
    (state_reg == dsfr_pkg::DSFR_SHIFT && frame_n_s) |=> state_reg == dsfr_pkg::DSFR_IDLE)
    else $error("abort did not return idle");

  word_done_c: cover property (@(posedge clk) disable iff (!rst_n) word_valid_reg);
  abort_c: cover property (@(posedge clk) disable iff (!rst_n) abort_reg);
  extra_clk_c: cover property (@(posedge clk) disable iff (!rst_n)
    state_reg == dsfr_pkg::DSFR_DONE && sclk_fall);
  // a frame start seen from idle, and a word arriving right before frame end
  frame_start_c: cover property (@(posedge clk) disable iff (!rst_n)
    state_reg == dsfr_pkg::DSFR_IDLE && frame_fall);
  tight_end_c: cover property (@(posedge clk) disable iff (!rst_n)
    word_valid_reg ##[1:8] state_reg == dsfr_pkg::DSFR_IDLE);
endmodule : dsfr_rx

// file: sim/dsfr_host.sv
/*
  host serial controller model: drives frame, serial clock and data pins.
  assumes the bench calls send and runs one frame at a time.
*/
`timescale 1ns/10ps
module dsfr_host (
  output logic frame_n_pin,
  output logic sclk_pin,
  output logic sdin_pin
);
  // idle: frame high, serial clock parked high outside frames
  initial begin
    frame_n_pin = 1'b1;
    sclk_pin = 1'b1;
    sdin_pin = 1'b0;
  end
  // bits beyond 24 flip the data line to prove extra falls are ignored
  task send(input logic [23:0] w, input int nb);
    frame_n_pin <= 1'b0;
    #40;
    for (int i = 0; i < nb; i++) begin
      sdin_pin <= (i < 24) ? w[23-i] : ~sdin_pin;
      #32 sclk_pin <= 1'b0;
      #32 sclk_pin <= 1'b1;
    end
    #20 frame_n_pin <= 1'b1;
    sdin_pin <= ~sdin_pin; // released line shows no stale value
    #60;
  endtask : send
endmodule : dsfr_host

// file: sim/dsfr_rx_tb_top.sv
/*
  self-checking bench for the serial frame receiver.
  assumes the host model drives the pins asynchronously to clk.
*/
`timescale 1ns/10ps
module dsfr_rx_tb_top;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  wire frame_n_pin, sclk_pin, sdin_pin;
  dsfr_pkg::dsfr_word_t word_reg;
  logic word_valid_reg, abort_reg, busy_reg;
  int err_count = 0, cmp_count = 0, vcnt = 0, acnt = 0;
  always #2.5 clk = ~clk;
  dsfr_host u_host (.frame_n_pin(frame_n_pin), .sclk_pin(sclk_pin), .sdin_pin(sdin_pin));
  dsfr_rx u_dut (.clk(clk), .rst_n(rst_n), .frame_n_pin(frame_n_pin), .sclk_pin(sclk_pin),
    .sdin_pin(sdin_pin), .word_reg(word_reg), .word_valid_reg(word_valid_reg),
    .abort_reg(abort_reg), .busy_reg(busy_reg));
  // count one-cycle pulses so a doubled pulse shows up
  always @(posedge clk) begin
    if (word_valid_reg === 1'b1) vcnt++;
    if (abort_reg === 1'b1) acnt++;
  end
  task check(input logic [23:0] seen, input logic [23:0] exp, input string msg);
    cmp_count++;
    if (seen !== exp) begin
      err_count++;
      $display("unexpected %0t %s %h/%h", $time, msg, seen, exp);
    end
  endtask : check
  task test_done;
    $display("errors %0d compares %0d", err_count, cmp_count);
    if (err_count == 0 && cmp_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : test_done
  // one frame of nb falls, then valid, abort and word compared
  task frame_case(input logic [23:0] w, input int nb, input logic [23:0] exp_w);
    int v0, a0;
    v0 = vcnt;
    a0 = acnt;
    u_host.send(w, nb);
    check(24'(vcnt - v0), (nb >= 24) ? 24'h000001 : 24'h000000, "valid");
    check(24'(acnt - a0), (nb < 24) ? 24'h000001 : 24'h000000, "abort");
    check(word_reg, exp_w, "word");
    check({23'h000000, busy_reg}, 24'h000000, "busy");
  endtask : frame_case
  // mid-run reset: word and valid checked cleared while held, then released; the next frame is a 12-bit abort
  task reset_case;
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (6) @(posedge clk);
    check(word_reg, 24'h000000, "reset word mid");
    check({23'h000000, word_valid_reg}, 24'h000000, "reset valid");
    rst_n <= 1'b1;
    @(posedge clk);
  endtask : reset_case
  initial begin
    #50000;
    err_count++;
    test_done;
  end
  initial begin
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    check(word_reg, 24'h000000, "reset word");
    frame_case(24'hA5C3F0, 24, 24'hA5C3F0);
    frame_case(24'h5A3C0F, 24, 24'h5A3C0F);
    frame_case(24'hFFFFFF, 10, 24'h5A3C0F);
    frame_case(24'h000001, 23, 24'h5A3C0F);
    reset_case;
    frame_case(24'h00FF00, 12, 24'h000000);
    frame_case(24'h8001FE, 27, 24'h8001FE);
    frame_case(24'h123456, 24, 24'h123456);
    test_done;
  end
endmodule : dsfr_rx_tb_top
